/* File: common/basic_timer_pkg.sv */
//////////////////////////////////////////////////////////////////////
// Function
// RQ1: The counter counts up in eight bits and on the wrap from all-ones to zero keeps counting and raises a time-out.
// RQ2: While the run enable bit is set, a time-out wakes the system from green low-power mode.
// RQ3: Mode bit 7 enables the timer, with 0 stopping the count and 1 letting it run.
// RQ4: Mode bits 6 to 4 pick the counting clock as the CPU clock divided by 256 for code 0 down to 2 for code 7.
// RQ5: Mode bits 3 and 2 only store the event timer clock source and never affect this counter.
// RQ6: The count register can be read and written, and a write loads a new starting count.
// RQ7: Software loads the count with 256 minus the wanted interval times the prescaled clock rate.
// RQ8: Software stops the timer, disables and clears the interrupt, programs rate and count, then enables both.
// RQ9: Each time-out sets the request flag, which stays set until software clears it by a bit write.
// RQ10: The count advances once per prescaled tick only while enabled and requests an interrupt only when enabled.
// RQ11: Reset clears the mode and count registers, stopping the timer at divide-by-256, with the low mode bits at zero.
//////////////////////////////////////////////////////////////////////
package basic_timer_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Register indices; the byte address is four times the index.
   localparam logic [ADDR_W-1:0] IDX_MODE = 12'h0D8;
   localparam logic [ADDR_W-1:0] IDX_COUNT = 12'h0D9;
   localparam logic [ADDR_W-1:0] ADDR_MODE = IDX_MODE << 2;
   localparam logic [ADDR_W-1:0] ADDR_COUNT = IDX_COUNT << 2;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h368;
   localparam logic [ADDR_W-1:0] ADDR_MASK = 12'h36C;

   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] MODE_WRITE_MASK = 8'hFC;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] DIV_FULL_MASK = 8'hFF;
   localparam int STATUS_TIMEOUT_BIT = 0;

   typedef struct packed {
      logic run_enable;
      logic [2:0] prescale_sel;
      logic [1:0] event_timer_clock_src_sel;
      logic [1:0] unused;
   } mode_fields_s;

   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } apb_req_s;

   typedef enum logic {ACC_IDLE, ACC_DONE} apb_state_e;

endpackage

/* File: design/prescale_tick.sv */
`timescale 1ns/1ns
module prescale_tick
   import basic_timer_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic enable_in,
   input wire logic [2:0] sel_in,
   output logic tick_out
);

   logic [7:0] div_reg;
   logic [7:0] div_next;
   logic [7:0] div_mask;

   // Free divider, cleared while stopped so the first tick takes a full period.
   always_comb
   begin
      div_next = enable_in ? div_reg + 8'h01 : 8'h00;
      // RQ4 divisor select
      div_mask = DIV_FULL_MASK >> sel_in;
      tick_out = enable_in && ((div_reg & div_mask) == div_mask);
   end

   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         div_reg <= 8'h00;
      end
      else
      begin
         div_reg <= div_next;
      end
   end

endmodule

/* File: design/basic_timer.sv */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
module basic_timer
   import basic_timer_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [DATA_W-1:0] pwdata_in,
   output logic [DATA_W-1:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic irq_out,
   output logic wake_out
);

   //////////////////////////////////////////////////////////////////////
   // Bus slave.

   apb_req_s req;
   apb_state_e acc_reg;
   apb_state_e acc_next;
   logic [DATA_W-1:0] prdata_reg;
   logic [DATA_W-1:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic addr_hit;
   logic [DATA_W-1:0] read_word;
   logic fire_write;
   logic wr_mode;
   logic wr_count;
   logic wr_status;
   logic wr_mask;

   mode_fields_s mode_reg;
   mode_fields_s mode_next;
   logic [7:0] count_reg;
   logic [7:0] count_next;
   logic flag_reg;
   logic flag_next;
   logic ien_reg;
   logic ien_next;
   logic irq_reg;
   logic irq_next;
   logic wake_reg;
   logic wake_next;
   logic tick;
   logic timeout;

   assign req = '{sel: psel_in, enable: penable_in, write: pwrite_in, addr: paddr_in, wdata: pwdata_in};

   always_comb
   begin
      addr_hit = (req.addr == ADDR_MODE) || (req.addr == ADDR_COUNT) ||
                 (req.addr == ADDR_STATUS) || (req.addr == ADDR_MASK);
      if (req.addr == ADDR_MODE)
      begin
         read_word = {24'h000000, mode_reg};
      end
      else if (req.addr == ADDR_COUNT)
      begin
         read_word = {24'h000000, count_reg};
      end
      else if (req.addr == ADDR_STATUS)
      begin
         read_word = {31'h0000000, flag_reg};
      end
      else if (req.addr == ADDR_MASK)
      begin
         read_word = {31'h0000000, ien_reg};
      end
      else
      begin
         read_word = 32'h00000000;
      end
   end

   // One wait cycle, then pready stands for one cycle.
   always_comb
   begin
      acc_next = acc_reg;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      prdata_next = prdata_reg;
      unique case (acc_reg)
         ACC_IDLE:
         begin
            if (req.sel && req.enable)
            begin
               acc_next = ACC_DONE;
               pready_next = 1'b1;
               pslverr_next = !addr_hit;
               prdata_next = req.write ? 32'h00000000 : read_word;
            end
         end
         ACC_DONE:
         begin
            acc_next = ACC_IDLE;
         end
      endcase
   end

   assign fire_write = (acc_reg == ACC_DONE) && req.sel && req.enable && req.write;
   assign wr_mode = fire_write && (req.addr == ADDR_MODE);
   assign wr_count = fire_write && (req.addr == ADDR_COUNT);
   assign wr_status = fire_write && (req.addr == ADDR_STATUS);
   assign wr_mask = fire_write && (req.addr == ADDR_MASK);

   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         acc_reg <= ACC_IDLE;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end
      else
      begin
         acc_reg <= acc_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
      end
   end

   assign prdata_out = prdata_reg;
   assign pready_out = pready_reg;
   assign pslverr_out = pslverr_reg;

   //////////////////////////////////////////////////////////////////////
   // Timer core.

   prescale_tick u_prescale
   (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .enable_in(mode_reg.run_enable),
      .sel_in(mode_reg.prescale_sel),
      .tick_out(tick)
   );

   // RQ1 wrap detection
   assign timeout = mode_reg.run_enable && tick && (count_reg == COUNT_MAX) && !wr_count;

   always_comb
   begin
      // RQ5 plain storage bits
      mode_next = wr_mode ? mode_fields_s'(req.wdata[7:0] & MODE_WRITE_MASK) : mode_reg;
      // RQ6 software load
      if (wr_count)
      begin
         count_next = req.wdata[7:0];
      end
      // RQ10 count on tick
      else if (mode_reg.run_enable && tick)
      begin
         count_next = count_reg + 8'h01;
      end
      // RQ3 hold while stopped
      else
      begin
         count_next = count_reg;
      end
      // RQ9 set wins over clear
      flag_next = timeout || (flag_reg && !(wr_status && req.wdata[STATUS_TIMEOUT_BIT]));
      ien_next = wr_mask ? req.wdata[STATUS_TIMEOUT_BIT] : ien_reg;
      // RQ10 gated request
      irq_next = flag_next && ien_next;
      // RQ2 green mode wake
      wake_next = timeout;
   end

   always_ff @(posedge mclk_in)
   begin
      // RQ11 reset values
      if (!rstn_in)
      begin
         mode_reg <= mode_fields_s'(MODE_RESET);
         count_reg <= COUNT_RESET;
         flag_reg <= 1'b0;
         ien_reg <= 1'b0;
         irq_reg <= 1'b0;
         wake_reg <= 1'b0;
      end
      else
      begin
         mode_reg <= mode_next;
         count_reg <= count_next;
         flag_reg <= flag_next;
         ien_reg <= ien_next;
         irq_reg <= irq_next;
         wake_reg <= wake_next;
      end
   end

   assign irq_out = irq_reg;
   assign wake_out = wake_reg;

   //////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rstn_in);

   property p_wrap_to_zero;
      mode_reg.run_enable && tick && count_reg == 8'hFF && !wr_count
      |=> count_reg == 8'h00 && flag_reg && wake_out;
   endproperty
   a_wrap_to_zero: assert property (p_wrap_to_zero) else $error("Wrap did not give zero and time-out."); // RQ1

   property p_wake_needs_run;
      wake_out |-> $past(mode_reg.run_enable) && $past(count_reg) == 8'hFF;
   endproperty
   a_wake_needs_run: assert property (p_wake_needs_run) else $error("Wake without running wrap."); // RQ2

   property p_stopped_holds;
      !mode_reg.run_enable && !wr_count |=> count_reg == $past(count_reg);
   endproperty
   a_stopped_holds: assert property (p_stopped_holds) else $error("Count moved while stopped."); // RQ3

   property p_fastest_rate;
      mode_reg.run_enable && mode_reg.prescale_sel == 3'h7 && tick ##1
      mode_reg.run_enable && mode_reg.prescale_sel == 3'h7 && !wr_mode |-> !tick ##1 tick;
   endproperty
   a_fastest_rate: assert property (p_fastest_rate) else $error("Divide-by-2 tick spacing wrong."); // RQ4

   property p_event_bits_store;
      wr_mode |=> mode_reg.event_timer_clock_src_sel == $past(req.wdata[3:2]);
   endproperty
   a_event_bits_store: assert property (p_event_bits_store) else $error("Event clock bits not stored."); // RQ5

   property p_count_load;
      wr_count |=> count_reg == $past(req.wdata[7:0]) && !wake_out;
   endproperty
   a_count_load: assert property (p_count_load) else $error("Count write not loaded."); // RQ6

   property p_flag_sticky;
      flag_reg && !(wr_status && req.wdata[0]) |=> flag_reg;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("Flag dropped without clear."); // RQ9

   property p_step_one;
      mode_reg.run_enable && tick && !wr_count |=> count_reg == $past(count_reg) + 8'h01;
   endproperty
   a_step_one: assert property (p_step_one) else $error("Count did not step by one."); // RQ10

   property p_irq_level;
      irq_out == (flag_reg && ien_reg);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("Interrupt level mismatch."); // RQ10

   property p_low_bits_zero;
      mode_reg.unused == 2'b00;
   endproperty
   a_low_bits_zero: assert property (p_low_bits_zero) else $error("Low mode bits not zero."); // RQ11

   c_timeout: cover property (timeout);
   c_irq_raised: cover property (!irq_out ##1 irq_out);
   c_clear_flag: cover property (flag_reg && wr_status ##1 !flag_reg);
   c_bad_addr: cover property (pready_out && pslverr_out);

endmodule

/* File: verification/basic_timer_tb.sv */
`timescale 1ns/1ns
module basic_timer_tb
   import basic_timer_pkg::*;
;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic wake;
   logic [31:0] seed = 32'h0000AFE4;
   logic [31:0] rd;
   logic err;
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int m_mode = 0;
   int m_count = 0;
   int m_flag = 0;
   int m_mask = 0;

   basic_timer basic_timer_inst (.mclk_in(mclk), .rstn_in(rstn), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .irq_out(irq), .wake_out(wake));

   always #4 mclk = ~mclk;

   //////////////////////////////////////////////////////////////////////
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task print_verdict();
      $display("Counts: %0d mismatches, %0d comparisons.", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   //////////////////////////////////////////////////////////////////////
   // Register writes also update the bench model.
   task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (a == ADDR_MODE)
         m_mode = int'(d[7:0] & MODE_WRITE_MASK);
      if (a == ADDR_COUNT)
         m_count = int'(d[7:0]);
      if (a == ADDR_MASK)
         m_mask = int'(d[0]);
      if (a == ADDR_STATUS && d[0])
         m_flag = 0;
   endtask

   task rdchk(input logic [ADDR_W-1:0] a);
      logic [31:0] e;
      e = (a == ADDR_MODE) ? m_mode : (a == ADDR_COUNT) ? m_count : (a == ADDR_STATUS) ? m_flag : m_mask;
      apb(1'b0, a, 32'h00000000);
      chk(rd, e, "register read");
      chk({31'h0, err}, 32'h00000000, "slave error on mapped read");
   endtask

   task run_one(input logic [2:0] s, input logic mk);
      int n;
      int div;
      wr(ADDR_MODE, 32'h00000000);
      wr(ADDR_MASK, 32'h00000000);
      wr(ADDR_STATUS, 32'h00000001);
      wr(ADDR_MODE, {24'h000000, 1'b0, s, 4'h0});
      wr(ADDR_COUNT, 32'h00000100 - 32'h00000002);
      wr(ADDR_MASK, {31'h0, mk});
      wr(ADDR_MODE, {24'h000000, 1'b1, s, 4'h0});
      div = 256 >> s;
      n = 0;
      while (wake !== 1'b1 && n < 2 * div + 8)
      begin
         @(posedge mclk);
         n++;
      end
      chk({31'h0, n >= 2 * div - 1 && n <= 2 * div + 4}, 32'h00000001, "time-out moment");
      chk({31'h0, irq}, {31'h0, mk}, "interrupt gated by enable");
      m_flag = 1;
      m_count = 0;
      wr(ADDR_MODE, {24'h000000, 1'b0, s, 4'h0});
      rdchk(ADDR_STATUS);
      if (s < 3'h4)
         rdchk(ADDR_COUNT);
      $display("Test time-out rate %0d mask %0d done.", s, mk);
   endtask

   //////////////////////////////////////////////////////////////////////
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         num_errors++;
         $display("[FAIL] %0t run did not finish in time", $time);
         print_verdict();
      end
   end

   initial
   begin
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      rdchk(ADDR_MODE);
      rdchk(ADDR_COUNT);
      rdchk(ADDR_STATUS);
      rdchk(ADDR_MASK);
      $display("Test reset values done.");
      wr(ADDR_MODE, (xs() & 32'hFFFFFF00) | 32'h0000007F);
      rdchk(ADDR_MODE);
      wr(ADDR_COUNT, xs());
      rdchk(ADDR_COUNT);
      repeat (600) @(posedge mclk);
      rdchk(ADDR_COUNT);
      $display("Test storage and hold done.");
      apb(1'b1, 12'h370, xs());
      chk({31'h0, err}, 32'h00000001, "unmapped write error");
      apb(1'b0, 12'h370, 32'h00000000);
      chk({31'h0, err}, 32'h00000001, "unmapped read error");
      chk(rd, 32'h00000000, "unmapped read data");
      rdchk(ADDR_MODE);
      $display("Test unmapped access done.");
      run_one(3'h7, 1'b0);
      for (int i = 0; i < 8; i++)
         run_one(i[2:0], 1'b1);
      wr(ADDR_STATUS, 32'h00000000);
      rdchk(ADDR_STATUS);
      chk({31'h0, irq}, 32'h00000001, "interrupt held while flag set");
      wr(ADDR_MASK, 32'h00000000);
      @(posedge mclk);
      chk({31'h0, irq}, 32'h00000000, "interrupt masked");
      wr(ADDR_STATUS, 32'h00000001);
      rdchk(ADDR_STATUS);
      $display("Test sticky flag done.");
      print_verdict();
   end
endmodule
